// [rtl/std_timer.sv]
// standard 16-bit timer: counter, comparators A and P, output pin, capture
// assumes register master on sys_clk_i; pins are asynchronous to it
//
// Function
// - pause bit holds counter; clearing resumes from held value
// - three-bit field picks system/4, system, high/16, high/64, sub, pin edges
// - counter-on rising clears counter; falling keeps residual value
// - counter-on low stops counting and turns timer off
// - counter-on rising restores output initial level in compare/pwm modes
// - control 0 low three bits read zero
// - two-bit mode: compare, capture, pwm/single pulse, timer/counter
// - compare mode on A match: keep, low, high or toggle output
// - pwm mode function: inactive, active, pwm, single pulse
// - capture mode: rising, falling, both edges, or disabled
// - requested level equal to initial level gives no pin change
// - init level sets pre-match level or pwm active level
// - invert bit inverts output pin; ignored in timer/counter mode
// - swap bit exchanges period and duty roles of P and A
// - clear source one clears on A match, zero on P or overflow
// - overflow clear only when compare P is zero
// - clear source ignored in pwm, single pulse and capture modes
// - counter readable as low and high read-only bytes
// - compare A read/write pair, compare P single byte register
// - output pin undefined in timer/counter mode
// - 16-bit up counter on selected clock
// - compare P matches counter bits 15..8; zero means 65536 clocks
// - clear source one raises only A flag, never P flag, in compare and timer/counter modes
`timescale 1ns/1ps
module std_timer
    import std_timer_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic ext_clock_pin_i,
    input wire logic capture_input_pin_i,
    input wire logic high_speed_clock_en_i,
    input wire logic sub_clock_en_i,
    output logic timer_output_pin_o,
    output logic timer_output_pin_oe_o,
    output logic cmp_a_flag_o,
    output logic cmp_p_flag_o
);
    // ************************************************************
    // register port
    // ************************************************************
    reg_req_type req;
    ctl0_type ctl0_r;
    ctl1_type ctl1_r;
    logic [15:0] cnt_r;
    logic [15:0] cmpa_r;
    logic [7:0] cmpp_r;
    logic cap_ev;
    logic [7:0] rdata_r;
    logic cmp_a_flag_r;
    logic cmp_p_flag_r;
    logic cap_flag_r;
    logic out_r;
    logic on_d_r;
    logic sp_done_r;
    logic [7:0] sys4_div_r;
    logic [7:0] h_div_r;
    logic ext_s1_r, ext_s2_r, ext_s3_r;
    logic cap_s1_r, cap_s2_r, cap_s3_r;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    wire wr_ctl0 = req.wr && req.addr == ADDR_CTL0;
    wire wr_ctl1 = req.wr && req.addr == ADDR_CTL1;
    wire wr_cmpa_lo = req.wr && req.addr == ADDR_CMPA_LO;
    wire wr_cmpa_hi = req.wr && req.addr == ADDR_CMPA_HI;
    wire wr_cmpp = req.wr && req.addr == ADDR_CMPP;
    wire wr_flags = req.wr && req.addr == ADDR_FLAGS;

    logic [7:0] rd_mux;
    always_comb begin
        unique case (req.addr)
            ADDR_CTL0: rd_mux = ctl0_r & CTL0_MASK;
            ADDR_CTL1: rd_mux = ctl1_r;
            ADDR_CNT_LO: rd_mux = cnt_r[7:0];
            ADDR_CNT_HI: rd_mux = cnt_r[15:8];
            ADDR_CMPA_LO: rd_mux = cmpa_r[7:0];
            ADDR_CMPA_HI: rd_mux = cmpa_r[15:8];
            ADDR_CMPP: rd_mux = cmpp_r;
            ADDR_FLAGS: rd_mux = {5'h00, cap_flag_r, cmp_p_flag_r,
                                  cmp_a_flag_r};
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_r <= 8'h00;
        end else if (req.rd) begin
            rdata_r <= rd_mux;
        end else begin
            rdata_r <= 8'h00;
        end
    end
    assign rdata_o = rdata_r;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ctl0_r <= CTL0_RST;
            ctl1_r <= CTL1_RST;
            cmpa_r <= CNT_RST;
            cmpp_r <= 8'h00;
        end else begin
            if (wr_ctl0) begin
                ctl0_r <= req.wdata & CTL0_MASK;
            end
            if (wr_ctl1) begin
                ctl1_r <= req.wdata;
            end
            if (wr_cmpa_lo) begin
                cmpa_r[7:0] <= req.wdata;
            end
            if (wr_cmpa_hi) begin
                cmpa_r[15:8] <= req.wdata;
            end
            // captured count lands in the compare A pair for software
            if (cap_ev) begin
                cmpa_r <= cnt_r;
            end
            if (wr_cmpp) begin
                cmpp_r <= req.wdata;
            end
        end
    end

    // ************************************************************
    // pin synchronisers and clock selection
    // ************************************************************
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
            cap_s1_r <= 1'b0;
            cap_s2_r <= 1'b0;
            cap_s3_r <= 1'b0;
        end else begin
            ext_s1_r <= ext_clock_pin_i;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
            cap_s1_r <= capture_input_pin_i;
            cap_s2_r <= cap_s1_r;
            cap_s3_r <= cap_s2_r;
        end
    end

    // dividers run free; phase vs counter-on is not aligned
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sys4_div_r <= 8'h00;
            h_div_r <= 8'h00;
        end else begin
            sys4_div_r <= (sys4_div_r == 8'(SYS4_DIV - 1)) ? 8'h00
                          : sys4_div_r + 8'h01;
            if (high_speed_clock_en_i) begin
                h_div_r <= (h_div_r == 8'(DIV64 - 1)) ? 8'h00
                           : h_div_r + 8'h01;
            end
        end
    end

    wire ext_rise = ext_s2_r && !ext_s3_r;
    wire ext_fall = !ext_s2_r && ext_s3_r;
    wire h16_tick = high_speed_clock_en_i && h_div_r[3:0] == 4'hF;
    wire h64_tick = high_speed_clock_en_i && h_div_r == 8'(DIV64 - 1);

    logic tick;
    always_comb begin
        unique case (clk_src_type'(ctl0_r.clk_src_sel))
            CK_SYS4: tick = sys4_div_r == 8'(SYS4_DIV - 1);
            CK_SYS: tick = 1'b1;
            CK_H16: tick = h16_tick;
            CK_H64: tick = h64_tick;
            CK_SUB0, CK_SUB1: tick = sub_clock_en_i;
            CK_PIN_RISE: tick = ext_rise;
            CK_PIN_FALL: tick = ext_fall;
        endcase
    end

    // ************************************************************
    // counter and comparators
    // ************************************************************
    wire on_rise = ctl0_r.counter_on && !on_d_r;
    wire run = ctl0_r.counter_on && !ctl0_r.pause_ctl;
    wire adv = run && tick;
    wire [1:0] mode = ctl1_r.op_mode_sel;
    wire cmp_like = mode == MODE_CMP || mode == MODE_TMR;
    wire ovf = adv && cnt_r == CNT_MAX;
    // top byte reaching P ends the period; zero means full wrap
    // overflow stands in for the P match only when P is zero
    wire p_hit = (cmpp_r == 8'h00) ? ovf
                 : adv && cnt_r == {cmpp_r - 8'h01, 8'hFF};
    wire a_hit = adv && cnt_r == cmpa_r;
    // clear source used only in compare and timer modes
    wire clr_a = cmp_like ? ctl1_r.clear_source_sel
                          : ctl1_r.duty_period_swap;
    // overflow clears only when P is zero (covered by p_hit)
    wire cnt_clr = clr_a ? a_hit : p_hit;
    wire set_p = p_hit && !(cmp_like && ctl1_r.clear_source_sel);

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cnt_r <= CNT_RST;
            on_d_r <= 1'b0;
        end else begin
            on_d_r <= ctl0_r.counter_on;
            if (on_rise) begin
                cnt_r <= CNT_RST;
            end else if (adv) begin
                cnt_r <= cnt_clr ? CNT_RST : cnt_r + 16'h0001;
            end
        end
    end

    // flags: set wins over software clear (write one to clear)
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cmp_a_flag_r <= 1'b0;
            cmp_p_flag_r <= 1'b0;
            cap_flag_r <= 1'b0;
        end else begin
            cmp_a_flag_r <= a_hit || (cmp_a_flag_r &&
                            !(wr_flags && req.wdata[0]));
            cmp_p_flag_r <= set_p || (cmp_p_flag_r &&
                            !(wr_flags && req.wdata[1]));
            cap_flag_r <= cap_ev || (cap_flag_r &&
                          !(wr_flags && req.wdata[2]));
        end
    end
    assign cmp_a_flag_o = cmp_a_flag_r;
    assign cmp_p_flag_o = cmp_p_flag_r;

    // ************************************************************
    // capture
    // ************************************************************
    wire cap_rise = cap_s2_r && !cap_s3_r;
    wire cap_fall = !cap_s2_r && cap_s3_r;
    always_comb begin
        unique case (ctl1_r.pin_function_sel)
            2'h0: cap_ev = cap_rise;
            2'h1: cap_ev = cap_fall;
            2'h2: cap_ev = cap_rise || cap_fall;
            2'h3: cap_ev = 1'b0;
        endcase
        cap_ev = cap_ev && mode == MODE_CAP && ctl0_r.counter_on;
    end

    // ************************************************************
    // output pin
    // ************************************************************
    wire [15:0] duty = ctl1_r.duty_period_swap ? {cmpp_r, 8'h00} : cmpa_r;
    wire pwm_act = cnt_r < duty;
    logic out_nxt;
    always_comb begin
        out_nxt = out_r;
        if (on_rise) begin
            out_nxt = ctl1_r.output_init_level;
        end else if (mode == MODE_CMP && a_hit) begin
            unique case (ctl1_r.pin_function_sel)
                2'h0: out_nxt = out_r;
                2'h1: out_nxt = 1'b0;
                2'h2: out_nxt = 1'b1;
                2'h3: out_nxt = !out_r;
            endcase
        end else if (mode == MODE_PWM) begin
            unique case (ctl1_r.pin_function_sel)
                2'h0: out_nxt = !ctl1_r.output_init_level;
                2'h1: out_nxt = ctl1_r.output_init_level;
                2'h2: out_nxt = pwm_act ~^ ctl1_r.output_init_level;
                2'h3: out_nxt = (pwm_act && !sp_done_r && run)
                                ~^ ctl1_r.output_init_level;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            out_r <= 1'b0;
            sp_done_r <= 1'b0;
        end else begin
            out_r <= out_nxt;
            if (on_rise) begin
                sp_done_r <= 1'b0;
            end else if (mode == MODE_PWM && cnt_clr) begin
                sp_done_r <= 1'b1;
            end
        end
    end

    // no inversion and no drive in timer/counter mode
    assign timer_output_pin_o = (mode == MODE_TMR) ? 1'b0
                                : out_r ^ ctl1_r.output_invert;
    assign timer_output_pin_oe_o = mode != MODE_TMR && mode != MODE_CAP;

    // ************************************************************
    // assertions
    // ************************************************************
    property p_on_clear;
        @(posedge sys_clk_i) disable iff (rst_i)
        on_rise |=> cnt_r == CNT_RST;
    endproperty
    a_on_clear: assert property (p_on_clear)
        else $error("counter not cleared on switch on");

    property p_pause_hold;
        @(posedge sys_clk_i) disable iff (rst_i)
        (ctl0_r.pause_ctl && !on_rise) |=> $stable(cnt_r);
    endproperty
    a_pause_hold: assert property (p_pause_hold)
        else $error("counter moved while paused");

    property p_off_hold;
        @(posedge sys_clk_i) disable iff (rst_i)
        !ctl0_r.counter_on |=> $stable(cnt_r);
    endproperty
    a_off_hold: assert property (p_off_hold)
        else $error("counter moved while off");

    property p_init_level;
        @(posedge sys_clk_i) disable iff (rst_i)
        on_rise && mode != MODE_TMR && mode != MODE_CAP
        |=> out_r == $past(ctl1_r.output_init_level);
    endproperty
    a_init_level: assert property (p_init_level)
        else $error("output not at initial level");

    property p_ctl0_low;
        @(posedge sys_clk_i) disable iff (rst_i)
        rd_i && addr_i == ADDR_CTL0 |=> rdata_o[2:0] == 3'h0;
    endproperty
    a_ctl0_low: assert property (p_ctl0_low)
        else $error("unimplemented bits not zero");

    property p_no_p_flag;
        @(posedge sys_clk_i) disable iff (rst_i)
        cmp_like && ctl1_r.clear_source_sel && !cmp_p_flag_r
        |=> !cmp_p_flag_r;
    endproperty
    a_no_p_flag: assert property (p_no_p_flag)
        else $error("p flag raised with a clear source");

    property p_cmp_high;
        @(posedge sys_clk_i) disable iff (rst_i)
        mode == MODE_CMP && a_hit && !on_rise
        && ctl1_r.pin_function_sel == 2'h2 |=> out_r;
    endproperty
    a_cmp_high: assert property (p_cmp_high)
        else $error("output not high after match");

    property p_cnt_step;
        @(posedge sys_clk_i) disable iff (rst_i)
        adv && !on_rise && !cnt_clr |=> cnt_r == $past(cnt_r) + 16'h0001;
    endproperty
    a_cnt_step: assert property (p_cnt_step)
        else $error("counter did not step by one");

    property p_a_clear;
        @(posedge sys_clk_i) disable iff (rst_i)
        cmp_like && ctl1_r.clear_source_sel && a_hit && !on_rise
        |=> cnt_r == CNT_RST;
    endproperty
    a_a_clear: assert property (p_a_clear)
        else $error("a match did not clear counter");

    c_a_hit: cover property (@(posedge sys_clk_i) a_hit);
    c_p_hit: cover property (@(posedge sys_clk_i) p_hit);
    c_cap: cover property (@(posedge sys_clk_i) cap_ev);
endmodule

// [rtl/std_timer_pkg.sv]
// constants, field layout and types for the standard 16-bit timer
// assumes one 250 MHz system clock and a plain register port
package std_timer_pkg;
    localparam logic [2:0] ADDR_CTL0 = 3'h0;
    localparam logic [2:0] ADDR_CTL1 = 3'h1;
    localparam logic [2:0] ADDR_CNT_LO = 3'h2;
    localparam logic [2:0] ADDR_CNT_HI = 3'h3;
    localparam logic [2:0] ADDR_CMPA_LO = 3'h4;
    localparam logic [2:0] ADDR_CMPA_HI = 3'h5;
    localparam logic [2:0] ADDR_CMPP = 3'h6;
    localparam logic [2:0] ADDR_FLAGS = 3'h7;
    localparam logic [7:0] CTL0_RST = 8'h00;
    localparam logic [7:0] CTL1_RST = 8'h00;
    localparam logic [7:0] CTL0_MASK = 8'hF8;
    localparam int PAUSE_BIT = 7;
    localparam int ON_BIT = 3;
    localparam int HS_DIV = 2;
    localparam int SUB_DIV = 8;
    localparam int SYS4_DIV = 4;
    localparam int DIV16 = 16;
    localparam int DIV64 = 64;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;

    typedef enum logic [1:0] {
        MODE_CMP = 2'h0,
        MODE_CAP = 2'h1,
        MODE_PWM = 2'h2,
        MODE_TMR = 2'h3
    } op_mode_type;

    typedef enum logic [2:0] {
        CK_SYS4 = 3'h0,
        CK_SYS = 3'h1,
        CK_H16 = 3'h2,
        CK_H64 = 3'h3,
        CK_SUB0 = 3'h4,
        CK_SUB1 = 3'h5,
        CK_PIN_RISE = 3'h6,
        CK_PIN_FALL = 3'h7
    } clk_src_type;

    typedef struct packed {
        logic pause_ctl;
        clk_src_type clk_src_sel;
        logic counter_on;
        logic [2:0] unused;
    } ctl0_type;

    typedef struct packed {
        op_mode_type op_mode_sel;
        logic [1:0] pin_function_sel;
        logic output_init_level;
        logic output_invert;
        logic duty_period_swap;
        logic clear_source_sel;
    } ctl1_type;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;
endpackage

// [tb/tb_std_timer.sv]
// self-checking bench for the standard timer through its register port
// assumes 250 MHz clock; high clock enable held high, sub tick every 8
`timescale 1ns/1ps
`define check_eq(nm, e, g) begin checks++; if ((g) !== (e)) begin \
    mismatches++; $display("mismatch %s expected %0h seen %0h", \
    nm, e, g); end end
module tb_std_timer import std_timer_pkg::*;;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic hs_en = 1'b1;
    logic sub_en = 1'b0;
    logic burst = 1'b0;
    logic cap_lvl = 1'b0;
    logic [7:0] rdata_o;
    logic ext_pin, cap_pin, pin_o, oe_o, fa, fp, lvl;
    logic [7:0] d, e;
    logic [15:0] v;
    logic [3:0] k;
    int mismatches = 0;
    int checks = 0;
    int hi_cnt, tol;
    int sub_cnt = 0;
    logic [7:0] pwm_ctl [6] = '{8'hA8, 8'hAA, 8'hAE, 8'h88, 8'h98, 8'hB8};
    logic [15:0] pwm_a [6] = '{16'h0080, 16'h0400, 16'h0400, 16'h0400,
        16'h0400, 16'h0400};
    int pwm_n [6] = '{512, 256, 768, 0, 1024, 256};
    int src_n [8] = '{160, 640, 40, 10, 80, 80, 10, 10};
    logic [3:0] cap_r = 4'h5;
    logic [3:0] cap_f = 4'h6;
    logic [7:0] reg_v [3] = '{8'h34, 8'h12, 8'hA5};

    std_timer std_timer_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .ext_clock_pin_i(ext_pin),
        .capture_input_pin_i(cap_pin), .high_speed_clock_en_i(hs_en),
        .sub_clock_en_i(sub_en), .timer_output_pin_o(pin_o),
        .timer_output_pin_oe_o(oe_o), .cmp_a_flag_o(fa), .cmp_p_flag_o(fp));
    timer_pin_model timer_pin_model_inst (.sys_clk_i(sys_clk_i),
        .burst_i(burst), .cap_level_i(cap_lvl), .ext_clock_pin_o(ext_pin),
        .capture_input_pin_o(cap_pin));

    // ************************************************************
    // clock, sub tick and bus tasks
    // ************************************************************
    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        sub_cnt <= (sub_cnt + 1) % 8;
        sub_en <= (sub_cnt == 7);
    end
    task automatic wr(input logic [2:0] a, input logic [7:0] x);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= x;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] x);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 x = rdata_o;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // full run is about 80000 cycles
    initial begin
        repeat (95000) @(posedge sys_clk_i);
        mismatches++;
        test_done;
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        repeat (4) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 7; a++) begin
            rd(3'(a), d);
            `check_eq("reset value", 8'h00, d)
        end
        wr(ADDR_CTL0, 8'h87);
        rd(ADDR_CTL0, d);
        `check_eq("ctl0 low bits", 8'h80, d)
        wr(ADDR_CTL0, 8'h00);
        wr(ADDR_CTL1, 8'h5A);
        rd(ADDR_CTL1, d);
        `check_eq("ctl1", 8'h5A, d)
        for (int a = 0; a < 3; a++) wr(ADDR_CMPA_LO + 3'(a), reg_v[a]);
        for (int a = 0; a < 3; a++) begin
            rd(ADDR_CMPA_LO + 3'(a), d);
            `check_eq("compare reg", reg_v[a], d)
        end
        wr(ADDR_CNT_LO, 8'h55);
        rd(ADDR_CNT_LO, d);
        `check_eq("counter read only", 8'h00, d)
        // compare output: every function, initial level and inversion
        wr(ADDR_CMPP, 8'h00);
        wr(ADDR_CMPA_HI, 8'h00);
        wr(ADDR_CMPA_LO, 8'h20);
        for (int i = 0; i < 16; i++) begin
            k = 4'(i);
            lvl = (k[3:2] == 2'd0) ? k[1] : (k[3:2] == 2'd3) ? ~k[1] : k[3];
            wr(ADDR_CTL0, 8'h10);
            wr(ADDR_CTL1, {2'b00, k, 2'b01});
            wr(ADDR_CTL0, 8'h18);
            cyc(3);
            `check_eq("pin initial", k[1] ^ k[0], pin_o)
            `check_eq("pin enable", 1'b1, oe_o)
            cyc(40);
            `check_eq("pin after match", lvl ^ k[0], pin_o)
        end
        // P below A: clear source picks the comparator and the flags
        wr(ADDR_CMPP, 8'h01);
        wr(ADDR_CMPA_HI, 8'h02);
        wr(ADDR_CMPA_LO, 8'h00);
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_CTL0, 8'h10);
            wr(ADDR_CTL1, 8'(1 - i));
            wr(ADDR_FLAGS, 8'h07);
            wr(ADDR_CTL0, 8'h18);
            cyc(1200);
            wr(ADDR_CTL0, 8'h10);
            rd(ADDR_FLAGS, d);
            `check_eq("match flags", 8'(i + 1), d & 8'h03)
            `check_eq("flag pins", 2'(i + 1), {fp, fa})
            rd(ADDR_CNT_HI, d);
            `check_eq("cleared by match", 1'b1, d <= 8'(2 - i))
        end
        // pwm: active cycles over 1024, four whole periods only where P sets the 256-cycle period
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_CTL0, 8'h10);
            wr(ADDR_CTL1, pwm_ctl[i]);
            wr(ADDR_CMPA_LO, pwm_a[i][7:0]);
            wr(ADDR_CMPA_HI, pwm_a[i][15:8]);
            wr(ADDR_CTL0, 8'h18);
            hi_cnt = 0;
            repeat (1024) begin
                cyc(1);
                hi_cnt += int'(pin_o);
            end
            `check_eq("pwm active", 1'b1, 1'(hi_cnt >= pwm_n[i] - 4 &&
                hi_cnt <= pwm_n[i] + 4))
        end
        // capture edge selection, rise then fall
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CTL0, 8'h10);
            wr(ADDR_CTL1, {2'b01, 2'(i), 4'h0});
            wr(ADDR_CTL0, 8'h18);
            for (int s = 0; s < 2; s++) begin
                wr(ADDR_FLAGS, 8'h07);
                cap_lvl <= (s == 0);
                cyc(10);
                rd(ADDR_FLAGS, d);
                `check_eq("capture", s ? cap_f[i] : cap_r[i], d[2])
            end
        end
        // every clock source, counted while running alone
        wr(ADDR_CTL0, 8'h10);
        wr(ADDR_CTL1, 8'hC0);
        wr(ADDR_CMPP, 8'h00);
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_CTL0, {1'b0, 3'(c), 4'h8});
            `check_eq("pin enable off", 1'b0, oe_o)
            if (c < 6) begin
                cyc(640);
            end else begin
                burst <= 1'b1;
                cyc(1);
                burst <= 1'b0;
                cyc(100);
            end
            wr(ADDR_CTL0, {1'b0, 3'(c), 4'h0});
            rd(ADDR_CNT_LO, v[7:0]);
            rd(ADDR_CNT_HI, v[15:8]);
            tol = (c < 6) ? 2 : 0;
            `check_eq("source count", 1'b1, 1'(int'(v) + tol >= src_n[c] &&
                int'(v) <= src_n[c] + tol))
        end
        // pause holds, off keeps residue, switching on clears
        wr(ADDR_CTL0, 8'h18);
        cyc(100);
        wr(ADDR_CTL0, 8'h98);
        rd(ADDR_CNT_LO, d);
        cyc(50);
        rd(ADDR_CNT_LO, e);
        `check_eq("paused", d, e)
        wr(ADDR_CTL0, 8'h18);
        cyc(50);
        wr(ADDR_CTL0, 8'h10);
        rd(ADDR_CNT_LO, e);
        `check_eq("resumed", 1'b1, 1'(e - d >= 50 && e - d <= 56))
        cyc(50);
        rd(ADDR_CNT_LO, d);
        `check_eq("off keeps", e, d)
        wr(ADDR_CTL0, 8'h18);
        wr(ADDR_CTL0, 8'h10);
        rd(ADDR_CNT_LO, d);
        `check_eq("on clears", 1'b1, d <= 8'h04)
        // zero compare P: P match only at overflow, after 65536 clocks
        wr(ADDR_FLAGS, 8'h07);
        wr(ADDR_CTL0, 8'h18);
        cyc(30000);
        rd(ADDR_FLAGS, d);
        `check_eq("no early P", 8'h01, d & 8'h03)
        cyc(36000);
        rd(ADDR_FLAGS, d);
        `check_eq("overflow P", 8'h03, d & 8'h03)
        test_done;
    end
endmodule

// [tb/timer_pin_model.sv]
// pin-side partner: external count clock and capture input pin
// assumes the bench asks for bursts and levels just after sys_clk_i edges
`timescale 1ns/1ps
module timer_pin_model #(
    parameter int HALF = 4
) (
    input wire logic sys_clk_i,
    input wire logic burst_i,
    input wire logic cap_level_i,
    output logic ext_clock_pin_o,
    output logic capture_input_pin_o
);
    // ************************************************************
    // pin drivers
    // ************************************************************
    int unsigned left_r;
    int unsigned ph_r;
    initial begin
        left_r = 0;
        ph_r = 0;
        ext_clock_pin_o = 1'b0;
        capture_input_pin_o = 1'b0;
    end
    // ten whole pulses per request; pin rests low outside bursts
    always @(posedge sys_clk_i) begin
        capture_input_pin_o <= cap_level_i;
        if (burst_i && left_r == 0) begin
            left_r <= 20;
            ph_r <= 0;
        end else if (left_r != 0) begin
            if (ph_r == HALF - 1) begin
                ph_r <= 0;
                ext_clock_pin_o <= ~ext_clock_pin_o;
                left_r <= left_r - 1;
            end else begin
                ph_r <= ph_r + 1;
            end
        end
    end
endmodule
